// ### hw/cas_map.svh
// Register map, field positions, reset values and timing counts of the carrier acquisition sweep
//
// Function
// RULE1: Search confined to a symmetric window programmable from 100 Hz to 1.25 MHz.
// RULE2: Search mode with supplied demod offset starts acquisition at carrier plus offset.
// RULE3: Search mode with nonzero sweep time starts from the last lock offset.
// RULE4: Forced unlock in search mode drops lock and seeks strictly higher carrier.
// RULE5: Post-abort sweep moves upward only, wrapping from upper to lower window edge.
// RULE6: Re-acquisition searches a reduced window for a set time, then the full window.
// RULE7: Reduced window total width in hertz equals the configured symbol rate.
// RULE8: Reduced window duration comes from the sweep time setting in search mode.
// RULE9: Reduced window centred on commanded offset, else on the last lock offset.
// RULE10: Acquisition mode encoding: 0 is fast (default), 1 is search.
// RULE11: Zero sweep time disables the narrow re-acquisition behaviour.
// RULE12: Demod offset ignores writes in fast mode, is writable in search mode.
// RULE13: Lock status is high while a carrier is held, drops at once on abort or loss.
`ifndef CAS_MAP_SVH
`define CAS_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CAS_OFF_CTRL 8'h00
`define CAS_OFF_RANGE 8'h04
`define CAS_OFF_SWEEP 8'h08
`define CAS_OFF_SYMRATE 8'h0C
`define CAS_OFF_DEMOD 8'h10
`define CAS_OFF_STATUS 8'h14
`define CAS_OFF_LOCKOFF 8'h18
`define CAS_OFF_TUNE 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAS_CTRL_MODE 0
`define CAS_CTRL_CLROFF 1
`define CAS_CTRL_UNLOCK 2
`define CAS_STAT_LOCK 0
`define CAS_STAT_NARROW 1
`define CAS_STAT_OFFSET 2

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define CAS_RANGE_MIN_HZ 21'h000064
`define CAS_RANGE_MAX_HZ 21'h1312D0
`define CAS_RANGE_RST 21'h007530
`define CAS_SWEEP_RST 16'h0000
`define CAS_SYMRATE_RST 24'h00FA00
`define CAS_STEP_HZ 1000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CAS_CLK_HZ 25000000
`define CAS_TICK_MS 1
`define CAS_DWELL_CYC 16

`endif

// ### hw/cas_pkg.sv
// Types shared by the carrier acquisition sweep modules
package cas_pkg;
	// Acquisition mode selector, codes fixed by software
	typedef enum logic {CAS_MODE_FAST = 1'b0, CAS_MODE_SEARCH = 1'b1} cas_mode_t;
	// Acquisition state
	typedef enum logic [1:0] {CAS_ST_FULL, CAS_ST_NARROW, CAS_ST_LOCKED} cas_state_t;
	// Signed frequency offset from the receive carrier setting, in Hz
	typedef logic signed [25:0] cas_freq_t;
endpackage : cas_pkg

// ### hw/cas_regs.sv
// APB register file of the carrier acquisition sweep
`timescale 1ns/1ps
`include "cas_map.svh"
module cas_regs (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output cas_pkg::cas_mode_t mode, // Acquisition mode
	output logic [20:0] range_hz, // Half width of full window
	output logic [15:0] sweep_ms, // Narrow phase duration
	output logic [23:0] sym_rate, // Symbol rate in Hz
	output cas_pkg::cas_freq_t demod_off, // Commanded offset
	output logic off_set, // Commanded offset present
	output logic off_cmd, // Pulse after accepted offset write
	output logic unlock_req, // Pulse after unlock request
	input wire logic locked, // Lock status
	input wire logic narrow, // Narrow phase active
	input wire cas_pkg::cas_freq_t last_lock, // Last lock offset
	input wire cas_pkg::cas_freq_t tune // Current search point
);
	logic wr;
	logic mapped;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Zero wait states, so every access completes in one access cycle
	assign wr = psel && penable && pwrite;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Configuration registers, range clamped to its legal span
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode <= cas_pkg::CAS_MODE_FAST;
			range_hz <= `CAS_RANGE_RST;
			sweep_ms <= `CAS_SWEEP_RST;
			sym_rate <= `CAS_SYMRATE_RST;
		end else if (wr) begin
			unique case (paddr)
				`CAS_OFF_CTRL: begin
					// RULE10 mode encoding
					mode <= cas_pkg::cas_mode_t'(pwdata[`CAS_CTRL_MODE]);
				end
				`CAS_OFF_RANGE: begin
					// RULE1 window limits
					if (pwdata[31:21] != 11'h000 || pwdata[20:0] > `CAS_RANGE_MAX_HZ) begin
						range_hz <= `CAS_RANGE_MAX_HZ;
					end else if (pwdata[20:0] < `CAS_RANGE_MIN_HZ) begin
						range_hz <= `CAS_RANGE_MIN_HZ;
					end else begin
						range_hz <= pwdata[20:0];
					end
				end
				`CAS_OFF_SWEEP: sweep_ms <= pwdata[15:0];
				`CAS_OFF_SYMRATE: sym_rate <= pwdata[23:0];
				default: ;
			endcase
		end
	end

	// Commanded offset and the pulses that act on the sweep
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			demod_off <= '0;
			off_set <= 1'b0;
			off_cmd <= 1'b0;
			unlock_req <= 1'b0;
		end else begin
			off_cmd <= 1'b0;
			unlock_req <= wr && paddr == `CAS_OFF_CTRL && pwdata[`CAS_CTRL_UNLOCK];
			// RULE12 fast mode read only
			if (wr && paddr == `CAS_OFF_DEMOD && mode == cas_pkg::CAS_MODE_SEARCH) begin
				demod_off <= cas_pkg::cas_freq_t'(pwdata[25:0]);
				off_set <= 1'b1;
				off_cmd <= 1'b1;
			end else if (wr && paddr == `CAS_OFF_CTRL && pwdata[`CAS_CTRL_CLROFF]) begin
				off_set <= 1'b0;
			end
		end
	end

	// Read data captured in the setup cycle, held for the access cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`CAS_OFF_CTRL: prdata <= {31'h00000000, mode};
				`CAS_OFF_RANGE: prdata <= {11'h000, range_hz};
				`CAS_OFF_SWEEP: prdata <= {16'h0000, sweep_ms};
				`CAS_OFF_SYMRATE: prdata <= {8'h00, sym_rate};
				`CAS_OFF_DEMOD: prdata <= {{6{demod_off[25]}}, demod_off};
				`CAS_OFF_STATUS: prdata <= {29'h00000000, off_set, narrow, locked};
				`CAS_OFF_LOCKOFF: prdata <= {{6{last_lock[25]}}, last_lock};
				`CAS_OFF_TUNE: prdata <= {{6{tune[25]}}, tune};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule : cas_regs

// ### hw/cas_sweep.sv
// Carrier acquisition sweep controller with its APB register file
`timescale 1ns/1ps
`include "cas_map.svh"
module cas_sweep #(
	parameter int MS_CYCLES = `CAS_CLK_HZ / 1000 * `CAS_TICK_MS, // Clock cycles per sweep time unit
	parameter int DWELL = `CAS_DWELL_CYC, // Cycles spent on each search step
	parameter int STEP_HZ = `CAS_STEP_HZ // Search step size in Hz
) (
	input wire logic clock, // System clock, 25 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic det_valid, // Detector reports a lockable carrier
	input wire cas_pkg::cas_freq_t det_offset, // Offset of that carrier
	input wire logic lock_loss, // Held carrier has been lost
	output logic locked, // Carrier held
	output logic narrow, // Reduced window active
	output cas_pkg::cas_freq_t tune_offset, // Current search point
	output cas_pkg::cas_freq_t win_lo, // Lower window edge
	output cas_pkg::cas_freq_t win_hi // Upper window edge
);
	cas_pkg::cas_mode_t mode;
	cas_pkg::cas_state_t state_reg;
	cas_pkg::cas_freq_t demod_off, last_lock_reg, tune_reg, win_lo_reg, win_hi_reg;
	cas_pkg::cas_freq_t full_lo, full_hi, nar_lo, nar_hi, cur_lo, cur_hi, center, start_pt, step;
	logic [20:0] range_hz;
	logic [15:0] sweep_ms, ms_cnt_reg;
	logic [23:0] sym_rate;
	logic [31:0] cyc_cnt_reg, dwell_cnt_reg;
	logic off_set, off_cmd, unlock_req, locked_reg, start_pend_reg;
	logic search, timed, det_hit, dwell_done, narrow_done;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// One step up, wrapping to the lower edge past the upper edge
	function automatic cas_pkg::cas_freq_t cas_step_up(input cas_pkg::cas_freq_t f, input cas_pkg::cas_freq_t s,
			input cas_pkg::cas_freq_t lo, input cas_pkg::cas_freq_t hi);
		cas_pkg::cas_freq_t n;
		n = f + s;
		cas_step_up = (n > hi || n < f) ? lo : n;
	endfunction : cas_step_up

	function automatic logic cas_in_win(input cas_pkg::cas_freq_t f, input cas_pkg::cas_freq_t lo,
			input cas_pkg::cas_freq_t hi);
		cas_in_win = (f >= lo) && (f <= hi);
	endfunction : cas_in_win

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	cas_regs cas_regs_i (
		.clock(clock),
		.rst_n(rst_n),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mode(mode),
		.range_hz(range_hz),
		.sweep_ms(sweep_ms),
		.sym_rate(sym_rate),
		.demod_off(demod_off),
		.off_set(off_set),
		.off_cmd(off_cmd),
		.unlock_req(unlock_req),
		.locked(locked_reg),
		.narrow(narrow),
		.last_lock(last_lock_reg),
		.tune(tune_reg)
	);

	// ----------------------------------------
	// Windows and start point
	// ----------------------------------------
	assign search = (mode == cas_pkg::CAS_MODE_SEARCH);
	// RULE11 zero disables narrow
	assign timed = search && (sweep_ms != 16'h0000);
	assign step = cas_pkg::cas_freq_t'(STEP_HZ);
	// RULE1 full window
	assign full_hi = cas_pkg::cas_freq_t'({5'h00, range_hz});
	assign full_lo = -full_hi;
	// RULE9 narrow centre
	assign center = off_set ? demod_off : last_lock_reg;
	// RULE7 width equals symbol rate; odd rates keep the exact width
	assign nar_lo = center - cas_pkg::cas_freq_t'({3'h0, sym_rate[23:1]});
	assign nar_hi = nar_lo + cas_pkg::cas_freq_t'({2'h0, sym_rate});
	assign cur_lo = (state_reg == cas_pkg::CAS_ST_NARROW) ? nar_lo : full_lo;
	assign cur_hi = (state_reg == cas_pkg::CAS_ST_NARROW) ? nar_hi : full_hi;
	// RULE2 commanded start
	// RULE3 last lock start
	assign start_pt = (search && off_set) ? demod_off : (timed ? last_lock_reg : '0);
	assign det_hit = det_valid && (state_reg != cas_pkg::CAS_ST_LOCKED) && cas_in_win(det_offset, cur_lo, cur_hi);
	assign dwell_done = (dwell_cnt_reg == 32'(DWELL - 1));
	assign narrow_done = (ms_cnt_reg >= sweep_ms);

	// ----------------------------------------
	// Acquisition sequence
	// ----------------------------------------
	// Lock capture has priority so a carrier seen during a step is not skipped
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= cas_pkg::CAS_ST_FULL;
			tune_reg <= '0;
			locked_reg <= 1'b0;
			last_lock_reg <= '0;
			start_pend_reg <= 1'b1;
		end else begin
			start_pend_reg <= 1'b0;
			unique case (state_reg)
				cas_pkg::CAS_ST_FULL, cas_pkg::CAS_ST_NARROW: begin
					if (det_hit) begin
						// RULE13 lock held
						state_reg <= cas_pkg::CAS_ST_LOCKED;
						locked_reg <= 1'b1;
						last_lock_reg <= det_offset;
					end else if (start_pend_reg) begin
						// RULE3 initial point
						tune_reg <= start_pt;
					end else if (off_cmd) begin
						// RULE2 restart at offset
						tune_reg <= demod_off;
						state_reg <= timed ? cas_pkg::CAS_ST_NARROW : cas_pkg::CAS_ST_FULL;
					end else if (state_reg == cas_pkg::CAS_ST_NARROW && (narrow_done || !timed)) begin
						// RULE6 back to full
						state_reg <= cas_pkg::CAS_ST_FULL;
					end else if (search && dwell_done) begin
						// RULE5 upward with wrap
						tune_reg <= cas_step_up(tune_reg, step, cur_lo, cur_hi);
					end
				end
				cas_pkg::CAS_ST_LOCKED: begin
					if (unlock_req && search) begin
						// RULE4 seek next higher
						state_reg <= cas_pkg::CAS_ST_FULL;
						locked_reg <= 1'b0;
						tune_reg <= cas_step_up(last_lock_reg, step, full_lo, full_hi);
					end else if (lock_loss || unlock_req) begin
						// RULE13 drop lock
						locked_reg <= 1'b0;
						if (timed) begin
							// RULE6 narrow first
							state_reg <= cas_pkg::CAS_ST_NARROW;
							tune_reg <= center;
						end else begin
							state_reg <= cas_pkg::CAS_ST_FULL;
							tune_reg <= start_pt;
						end
					end
				end
				default: state_reg <= cas_pkg::CAS_ST_FULL;
			endcase
		end
	end

	// ----------------------------------------
	// Narrow phase timer
	// ----------------------------------------
	// RULE8 duration from sweep time
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cyc_cnt_reg <= 32'h00000000;
			ms_cnt_reg <= 16'h0000;
		end else if (state_reg != cas_pkg::CAS_ST_NARROW || off_cmd) begin
			cyc_cnt_reg <= 32'h00000000;
			ms_cnt_reg <= 16'h0000;
		end else if (cyc_cnt_reg == 32'(MS_CYCLES - 1)) begin
			cyc_cnt_reg <= 32'h00000000;
			ms_cnt_reg <= ms_cnt_reg + 16'h0001;
		end else begin
			cyc_cnt_reg <= cyc_cnt_reg + 32'h00000001;
		end
	end

	// Dwell per search step; restarts whenever the search point is moved
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dwell_cnt_reg <= 32'h00000000;
		end else if (state_reg == cas_pkg::CAS_ST_LOCKED || dwell_done || off_cmd) begin
			dwell_cnt_reg <= 32'h00000000;
		end else begin
			dwell_cnt_reg <= dwell_cnt_reg + 32'h00000001;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Window edges registered so the detector sees stable bounds
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			win_lo_reg <= '0;
			win_hi_reg <= '0;
		end else begin
			win_lo_reg <= cur_lo;
			win_hi_reg <= cur_hi;
		end
	end

	assign win_lo = win_lo_reg;
	assign win_hi = win_hi_reg;
	assign tune_offset = tune_reg;
	assign locked = locked_reg;
	assign narrow = (state_reg == cas_pkg::CAS_ST_NARROW);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_win_full;
		@(posedge clock) disable iff (!rst_n)
		!narrow && $stable(range_hz) |=> win_hi_reg == $past(full_hi) && win_lo_reg == -win_hi_reg;
	endproperty
	a_win_full: assert property (p_win_full) else $error("full window not symmetric about range"); // RULE1

	property p_off_start;
		@(posedge clock) disable iff (!rst_n)
		off_cmd && !det_hit && !locked_reg |=> tune_reg == $past(demod_off);
	endproperty
	a_off_start: assert property (p_off_start) else $error("search did not restart at commanded offset"); // RULE2

	property p_abort_up;
		@(posedge clock) disable iff (!rst_n)
		state_reg == cas_pkg::CAS_ST_LOCKED && unlock_req && search
			|=> !locked_reg && (tune_reg > $past(last_lock_reg) || tune_reg == $past(full_lo));
	endproperty
	a_abort_up: assert property (p_abort_up) else $error("abort did not move search above aborted carrier"); // RULE4

	property p_wrap;
		@(posedge clock) disable iff (!rst_n)
		state_reg == cas_pkg::CAS_ST_FULL && search && dwell_done && !det_hit && !off_cmd && !start_pend_reg
			&& tune_reg + step > cur_hi |=> tune_reg == $past(full_lo);
	endproperty
	a_wrap: assert property (p_wrap) else $error("sweep did not wrap to lower edge"); // RULE5

	// Elapsed time ends the phase unless a lock or a new offset takes over
	property p_narrow_end;
		@(posedge clock) disable iff (!rst_n)
		narrow && narrow_done && !det_hit && !off_cmd |=> !narrow;
	endproperty
	a_narrow_end: assert property (p_narrow_end) else $error("narrow phase outlived sweep time"); // RULE6

	property p_width;
		@(posedge clock) disable iff (!rst_n)
		narrow |=> win_hi_reg - win_lo_reg == cas_pkg::cas_freq_t'({2'h0, $past(sym_rate)})
			&& win_lo_reg <= $past(center) && win_hi_reg >= $past(center);
	endproperty
	a_width: assert property (p_width) else $error("narrow window width differs from symbol rate"); // RULE7

	property p_center;
		@(posedge clock) disable iff (!rst_n)
		state_reg == cas_pkg::CAS_ST_LOCKED && lock_loss && !unlock_req && timed |=> narrow && tune_reg == $past(center);
	endproperty
	a_center: assert property (p_center) else $error("narrow search not centred after loss"); // RULE9

	property p_zero_time;
		@(posedge clock) disable iff (!rst_n)
		!timed |=> !narrow;
	endproperty
	a_zero_time: assert property (p_zero_time) else $error("narrow phase with zero sweep time"); // RULE11

	property p_fast_ro;
		@(posedge clock) disable iff (!rst_n)
		!search ##1 !search |-> $stable(demod_off) && !off_cmd;
	endproperty
	a_fast_ro: assert property (p_fast_ro) else $error("demod offset changed in fast mode"); // RULE12

	property p_lock_drop;
		@(posedge clock) disable iff (!rst_n)
		state_reg == cas_pkg::CAS_ST_LOCKED && (lock_loss || unlock_req) |=> !locked && !$past(det_hit);
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock status not dropped at once"); // RULE13

	c_lock: cover property (@(posedge clock) disable iff (!rst_n) det_hit ##1 locked);
	c_abort: cover property (@(posedge clock) disable iff (!rst_n) locked && unlock_req && search ##1 !locked);
	c_wrap: cover property (@(posedge clock) disable iff (!rst_n) search && dwell_done && tune_reg + step > cur_hi);
	c_narrow_out: cover property (@(posedge clock) disable iff (!rst_n) narrow ##1 !narrow && !locked);
endmodule : cas_sweep

// ### testbench/cas_det_model.sv
// Carrier detector model that reports carriers as the search point reaches them
`timescale 1ns/1ps
module cas_det_model #(
	parameter int C0 = 3000, // First carrier offset in Hz
	parameter int C1 = -4000 // Second carrier offset in Hz
) (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic en, // Carriers present on the input
	input wire logic locked, // Lock status from the sweep
	input wire cas_pkg::cas_freq_t tune_offset, // Current search point
	input wire cas_pkg::cas_freq_t win_lo, // Lower window edge
	input wire cas_pkg::cas_freq_t win_hi, // Upper window edge
	output logic det_valid, // Lockable carrier found
	output cas_pkg::cas_freq_t det_offset // Offset of that carrier
);
	// ----------------------------------------
	// Detection
	// ----------------------------------------
	// Reports only inside the window; the offset toggles when idle so stale values never match by luck
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			det_valid <= 1'b0;
			det_offset <= '0;
		end else if (en && !locked && tune_offset >= win_lo && tune_offset <= win_hi &&
			(tune_offset == C0 || tune_offset == C1)) begin
			det_valid <= 1'b1;
			det_offset <= tune_offset;
		end else begin
			det_valid <= 1'b0;
			det_offset <= ~det_offset;
		end
	end
endmodule : cas_det_model

// ### testbench/test_cas_sweep.sv
// Self-checking testbench of the carrier acquisition sweep
`timescale 1ns/1ps
`include "cas_map.svh"
module test_cas_sweep;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int MSC = 10; // Shortened sweep time unit
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, lock_loss, en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic det_valid, locked, narrow, err;
	cas_pkg::cas_freq_t det_offset, tune_offset, win_lo, win_hi;
	int fail_count, n_compared, cyc, cnt;
	logic [31:0] lk;

	cas_sweep #(.MS_CYCLES(MSC), .DWELL(16), .STEP_HZ(1000)) cas_sweep_i (.clock(clock), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .det_valid(det_valid), .det_offset(det_offset),
		.lock_loss(lock_loss), .locked(locked), .narrow(narrow), .tune_offset(tune_offset),
		.win_lo(win_lo), .win_hi(win_hi));
	cas_det_model cas_det_model_i (.clock(clock), .rst_n(rst_n), .en(en), .locked(locked),
		.tune_offset(tune_offset), .win_lo(win_lo), .win_hi(win_hi), .det_valid(det_valid),
		.det_offset(det_offset));

	// Clock at 25 MHz
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Timeout guard, well above the expected run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED at %0t: timeout", $time);
			complete_run();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic chkf(input cas_pkg::cas_freq_t got, input int exp, input string msg);
		chk(32'(got), 32'(exp), msg);
	endtask : chkf

	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// No wait-state count assumed; the bench timeout ends a stuck slave
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Wait for the lock status to reach a level; the bench timeout ends a hang
	task automatic wait_lock(input logic v);
		while (locked !== v) begin
			@(posedge clock);
			#1;
		end
	endtask : wait_lock

	task automatic loss();
		@(posedge clock);
		lock_loss <= 1'b1;
		@(posedge clock);
		lock_loss <= 1'b0;
		#1;
	endtask : loss

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		fail_count = 0;
		n_compared = 0;
		cyc = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, lock_loss} = '0;
		paddr = '0;
		pwdata = '0;
		en = 1'b1;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chkf(win_hi, 30000, "reset window top");
		chkf(win_lo, -30000, "reset window bottom");
		apb(1'b0, `CAS_OFF_CTRL, 32'h0);
		chk(rd, 32'(cas_pkg::CAS_MODE_FAST), "default mode");
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, `CAS_OFF_RANGE, 32'h32);
		apb(1'b0, `CAS_OFF_RANGE, 32'h0);
		chk(rd, 32'h64, "range low clamp");
		apb(1'b1, `CAS_OFF_RANGE, 32'h1E8480);
		apb(1'b0, `CAS_OFF_RANGE, 32'h0);
		chk(rd, 32'h1312D0, "range high clamp");
		apb(1'b1, `CAS_OFF_RANGE, 32'h1388);
		apb(1'b1, `CAS_OFF_DEMOD, 32'h7D0);
		apb(1'b0, `CAS_OFF_DEMOD, 32'h0);
		chk(rd, 32'h0, "offset read only in fast");
		$display("test registers done");

		// Search mode start point and upward pseudo-sweep
		apb(1'b1, `CAS_OFF_CTRL, 32'(cas_pkg::CAS_MODE_SEARCH));
		apb(1'b1, `CAS_OFF_DEMOD, 32'h7D0);
		repeat (2) @(posedge clock);
		#1;
		chkf(tune_offset, 2000, "start at commanded offset");
		chkf(win_hi, 5000, "full window top");
		wait_lock(1'b1);
		apb(1'b0, `CAS_OFF_LOCKOFF, 32'h0);
		chk(rd, 32'd3000, "first carrier above offset");
		apb(1'b0, `CAS_OFF_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1, "lock status bit");
		apb(1'b1, `CAS_OFF_CTRL, 32'h5);
		@(posedge clock);
		#1;
		chk({31'h0, locked}, 32'h0, "unlock drops lock");
		chkf(tune_offset, 4000, "search strictly above");
		wait_lock(1'b1);
		apb(1'b0, `CAS_OFF_LOCKOFF, 32'h0);
		chk(rd, 32'hFFFFF060, "wrap to lower edge");
		apb(1'b1, `CAS_OFF_CTRL, 32'h5);
		wait_lock(1'b0);
		wait_lock(1'b1);
		apb(1'b0, `CAS_OFF_LOCKOFF, 32'h0);
		chk(rd, 32'd3000, "next carrier upward");
		$display("test pseudo-sweep done");

		// Narrow phase centred on the commanded offset
		apb(1'b1, `CAS_OFF_SYMRATE, 32'hFA0);
		apb(1'b1, `CAS_OFF_SWEEP, 32'h2);
		en <= 1'b0;
		loss();
		chk({31'h0, locked}, 32'h0, "loss drops lock");
		chk({31'h0, narrow}, 32'h1, "narrow after loss");
		@(posedge clock);
		#1;
		chkf(tune_offset, 2000, "narrow centre offset");
		chkf(win_lo, 0, "narrow bottom");
		chkf(win_hi, 4000, "narrow top");
		// Sampled after each edge so the count sees settled state
		cnt = 1;
		while (narrow === 1'b1) begin
			@(posedge clock);
			#1;
			cnt = cnt + 1;
		end
		chk(32'(cnt >= 18 && cnt <= 22), 32'h1, "narrow duration");
		@(posedge clock);
		#1;
		chkf(win_hi, 5000, "back to full window");
		$display("test narrow offset done");

		// Narrow phase centred on the last lock, then disabled by zero sweep time
		apb(1'b1, `CAS_OFF_CTRL, 32'h3);
		en <= 1'b1;
		wait_lock(1'b1);
		apb(1'b0, `CAS_OFF_LOCKOFF, 32'h0);
		lk = rd;
		en <= 1'b0;
		loss();
		@(posedge clock);
		#1;
		chk(32'(tune_offset), lk, "narrow centre last lock");
		chk({31'h0, narrow}, 32'h1, "narrow with last lock");
		apb(1'b1, `CAS_OFF_SWEEP, 32'h0);
		en <= 1'b1;
		wait_lock(1'b1);
		en <= 1'b0;
		loss();
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, narrow}, 32'h0, "zero sweep time no narrow");
		chkf(win_hi, 5000, "full window kept");
		$display("test narrow last lock done");
		complete_run();
	end
endmodule : test_cas_sweep
